// ==== shared/cobx_cfg.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by every file of the clock output and bias block except the type package
// Notes: Register indices select one word on the register port
`ifndef COBX_CFG_SVH
`define COBX_CFG_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define COBX_IDX_BIAS_STS 2'h0
`define COBX_IDX_XO_CFG 2'h1
`define COBX_IDX_OD_CFG 2'h2
`define COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL 2'h3

// ****************************************************************
// Bias calibration status fields
// ****************************************************************
`define COBX_BS_DONE 0
`define COBX_BS_FAIL 1
`define COBX_BS_SEL_LO 2
`define COBX_BS_EFF_LO 5
`define COBX_BS_RAW 8

// ****************************************************************
// Crystal oscillator configuration fields and reset values
// ****************************************************************
`define COBX_XO_CAPIN_LO 0
`define COBX_XO_RSV0_LO 6
`define COBX_XO_CAPOUT_LO 8
`define COBX_XO_GAIN_LO 14
`define COBX_XO_LDO 16
`define COBX_XO_RSV1_LO 17
`define COBX_XO_CAP_RST 6'h1f
`define COBX_XO_GAIN_RST 2'h1
`define COBX_XO_LDO_RST 1'h1
`define COBX_XO_CAP_MAX 6'h2f

// ****************************************************************
// Output divider and driver fields and reset values
// ****************************************************************
`define COBX_OD_RATIO_LO 0
`define COBX_OD_LDO 15
`define COBX_OD_RATIO_RST 14'h0069
`define COBX_OD_RATIO_MIN 14'h000a
`define COBX_OD_LDO_RST 1'h1
`define COBX_DRV_PD 0
`define COBX_DRV_DIS 1
`define COBX_DRV_STATE_LO 2
`define COBX_DIS_LOW_LOW 2'h0
`define COBX_DIS_LOW_HIGH 2'h1
`define COBX_DIS_HIZ 2'h2
`define COBX_DIS_RUN 2'h3

// ****************************************************************
// Calibration timing
// ****************************************************************
`define COBX_CLK_MHZ 100
`define COBX_SETTLE_NS 200
`define COBX_SETTLE_CYC (((`COBX_SETTLE_NS * `COBX_CLK_MHZ) + 999) / 1000)
`define COBX_BIAS_DEFAULT 3'h4

`endif

// ==== shared/cobx_pkg.sv ====
// Purpose: Types shared by the clock output and bias block
// Assumes: Constants come from cobx_cfg.svh
// Notes: Holds types only
package cobx_pkg;

  // Calibration sequencer states
  typedef enum logic [2:0] {
    COBX_CAL_SETTLE,
    COBX_CAL_DECIDE,
    COBX_CAL_FINISH,
    COBX_CAL_DONE
  } cobx_cal_e;

  typedef logic [2:0] cobx_code_t;
  typedef logic [1:0] cobx_idx_t;

endpackage : cobx_pkg

// ==== hdl/cobx_bias_cal.sv ====
// Purpose: Successive approximation bias calibration, run once per reset
// Assumes: cmp_in is already synchronised to clk
// Notes: A high comparator keeps the trial bit set
`timescale 1ns/10ps
`include "cobx_cfg.svh"

module cobx_bias_cal (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmp_in,
  output cobx_pkg::cobx_code_t sel_code,
  output cobx_pkg::cobx_code_t eff_code,
  output logic cal_fail,
  output logic cal_done
);
  import cobx_pkg::*;

  localparam logic [7:0] SETTLE_LAST = 8'(`COBX_SETTLE_CYC - 1);

  cobx_cal_e state_q, state_d;
  cobx_code_t code_q, code_d;
  logic [1:0] bit_q, bit_d;
  logic [7:0] timer_q, timer_d;
  logic fail_q, fail_d;
  cobx_code_t trial;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state of the search
  always_comb begin
    trial = code_q;
    state_d = state_q;
    code_d = code_q;
    bit_d = bit_q;
    timer_d = timer_q;
    fail_d = fail_q;
    case (state_q)
      COBX_CAL_SETTLE: begin
        // Let the bias settle on each trial code before judging it
        if (timer_q == SETTLE_LAST) begin
          timer_d = 8'h00;
          state_d = COBX_CAL_DECIDE;
        end else begin
          timer_d = timer_q + 8'h01;
        end
      end
      COBX_CAL_DECIDE: begin
        trial[bit_q] = cmp_in;
        code_d = trial;
        if (bit_q == 2'h0) begin
          // Search ended against a rail: no code balances the comparator
          fail_d = ((trial == 3'h7) && cmp_in) ||
                   ((trial == 3'h0) && !cmp_in);
          state_d = COBX_CAL_FINISH;
        end else begin
          code_d[bit_q - 2'h1] = 1'b1;
          bit_d = bit_q - 2'h1;
          state_d = COBX_CAL_SETTLE;
        end
      end
      COBX_CAL_FINISH: state_d = COBX_CAL_DONE;
      COBX_CAL_DONE: state_d = COBX_CAL_DONE;
      default: state_d = COBX_CAL_DONE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= COBX_CAL_SETTLE;
      code_q <= 3'h4;
      bit_q <= 2'h2;
      timer_q <= 8'h00;
      fail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      code_q <= code_d;
      bit_q <= bit_d;
      timer_q <= timer_d;
      fail_q <= fail_d;
    end
  end

  // ****************************************************************
  // Results
  // ****************************************************************
  // A failed search applies the mid code rather than a rail value
  assign cal_done = (state_q == COBX_CAL_DONE);
  assign cal_fail = fail_q;
  assign sel_code = code_q;
  assign eff_code = (cal_done && fail_q) ? `COBX_BIAS_DEFAULT : code_q;

endmodule : cobx_bias_cal

// ==== hdl/cobx_regs.sv ====
// Purpose: Bias status, oscillator, divider and output driver registers
// Assumes: One register word per index on a simple serial port bridge
// Notes: Read data appears one cycle after reg_rd

`timescale 1ns/10ps
`include "cobx_cfg.svh"

module cobx_regs (
  input wire logic clk,
  input wire logic rst,
  input wire cobx_pkg::cobx_idx_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic bias_cmp_pin,
  input wire logic oe_pin_disable,
  input wire logic lvds_mode,
  output cobx_pkg::cobx_code_t bias_code_applied,
  output logic osc_regulator_on,
  output logic [1:0] osc_gain_boost,
  output logic [5:0] osc_cap_out,
  output logic [5:0] osc_cap_in,
  output logic divider_regulator_on,
  output logic clock_out_true,
  output logic clock_out_true_oe,
  output logic clock_out_complement,
  output logic clock_out_complement_oe
);
  import cobx_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [1:0] cmp_sync_q, cmp_sync_d;
  logic [1:0] oe_sync_q, oe_sync_d;

  // Both pins are asynchronous to clk
  always_comb begin
    cmp_sync_d = {cmp_sync_q[0], bias_cmp_pin};
    oe_sync_d = {oe_sync_q[0], oe_pin_disable};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_sync_q <= 2'h0;
      oe_sync_q <= 2'h0;
    end else begin
      cmp_sync_q <= cmp_sync_d;
      oe_sync_q <= oe_sync_d;
    end
  end

  // ****************************************************************
  // Bias calibration
  // ****************************************************************
  cobx_code_t sel_code;
  cobx_code_t eff_code;
  logic cal_fail;
  logic cal_done;

  cobx_bias_cal u_cal (
    .clk(clk),
    .rst(rst),
    .cmp_in(cmp_sync_q[1]),
    .sel_code(sel_code),
    .eff_code(eff_code),
    .cal_fail(cal_fail),
    .cal_done(cal_done)
  );

  assign bias_code_applied = eff_code;

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  logic [1:0] xo_rsv1_q, xo_rsv1_d;
  logic xo_ldo_q, xo_ldo_d;
  logic [1:0] xo_gain_q, xo_gain_d;
  logic [5:0] xo_capout_q, xo_capout_d;
  logic [1:0] xo_rsv0_q, xo_rsv0_d;
  logic [5:0] xo_capin_q, xo_capin_d;
  logic od_ldo_q, od_ldo_d;
  logic [13:0] od_ratio_q, od_ratio_d;
  logic [1:0] drv_state_q, drv_state_d;
  logic drv_dis_q, drv_dis_d;
  logic drv_pd_q, drv_pd_d;

  // Decode one word write
  always_comb begin
    xo_rsv1_d = xo_rsv1_q;
    xo_ldo_d = xo_ldo_q;
    xo_gain_d = xo_gain_q;
    xo_capout_d = xo_capout_q;
    xo_rsv0_d = xo_rsv0_q;
    xo_capin_d = xo_capin_q;
    od_ldo_d = od_ldo_q;
    od_ratio_d = od_ratio_q;
    drv_state_d = drv_state_q;
    drv_dis_d = drv_dis_q;
    drv_pd_d = drv_pd_q;
    if (reg_wr && (reg_addr == `COBX_IDX_XO_CFG)) begin
      xo_rsv1_d = reg_wdata[`COBX_XO_RSV1_LO +: 2];
      xo_ldo_d = reg_wdata[`COBX_XO_LDO];
      xo_gain_d = reg_wdata[`COBX_XO_GAIN_LO +: 2];
      xo_capout_d = reg_wdata[`COBX_XO_CAPOUT_LO +: 6];
      xo_rsv0_d = reg_wdata[`COBX_XO_RSV0_LO +: 2];
      xo_capin_d = reg_wdata[`COBX_XO_CAPIN_LO +: 6];
    end
    if (reg_wr && (reg_addr == `COBX_IDX_OD_CFG)) begin
      od_ldo_d = reg_wdata[`COBX_OD_LDO];
      od_ratio_d = reg_wdata[`COBX_OD_RATIO_LO +: 14];
    end
    if (reg_wr && (reg_addr == `COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL)) begin
      drv_state_d = reg_wdata[`COBX_DRV_STATE_LO +: 2];
      drv_dis_d = reg_wdata[`COBX_DRV_DIS];
      drv_pd_d = reg_wdata[`COBX_DRV_PD];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xo_rsv1_q <= 2'h0;
      xo_ldo_q <= `COBX_XO_LDO_RST;
      xo_gain_q <= `COBX_XO_GAIN_RST;
      xo_capout_q <= `COBX_XO_CAP_RST;
      xo_rsv0_q <= 2'h0;
      xo_capin_q <= `COBX_XO_CAP_RST;
      od_ldo_q <= `COBX_OD_LDO_RST;
      od_ratio_q <= `COBX_OD_RATIO_RST;
      drv_state_q <= `COBX_DIS_LOW_LOW;
      drv_dis_q <= 1'b0;
      drv_pd_q <= 1'b0;
    end else begin
      xo_rsv1_q <= xo_rsv1_d;
      xo_ldo_q <= xo_ldo_d;
      xo_gain_q <= xo_gain_d;
      xo_capout_q <= xo_capout_d;
      xo_rsv0_q <= xo_rsv0_d;
      xo_capin_q <= xo_capin_d;
      od_ldo_q <= od_ldo_d;
      od_ratio_q <= od_ratio_d;
      drv_state_q <= drv_state_d;
      drv_dis_q <= drv_dis_d;
      drv_pd_q <= drv_pd_d;
    end
  end

  // Reserved codes are kept as written but never reach the array
  function automatic logic [5:0] cap_limit(input logic [5:0] code);
    cap_limit = (code > `COBX_XO_CAP_MAX) ? `COBX_XO_CAP_MAX : code;
  endfunction : cap_limit

  assign osc_regulator_on = xo_ldo_q;
  assign osc_gain_boost = xo_gain_q;
  assign osc_cap_out = cap_limit(xo_capout_q);
  assign osc_cap_in = cap_limit(xo_capin_q);
  assign divider_regulator_on = od_ldo_q;

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = 32'h0000_0000;
      case (reg_addr)
        `COBX_IDX_BIAS_STS: begin
          rdata_d[`COBX_BS_DONE] = cal_done;
          rdata_d[`COBX_BS_FAIL] = cal_fail;
          rdata_d[`COBX_BS_SEL_LO +: 3] = sel_code;
          rdata_d[`COBX_BS_EFF_LO +: 3] = eff_code;
          rdata_d[`COBX_BS_RAW] = cmp_sync_q[1];
        end
        `COBX_IDX_XO_CFG: begin
          rdata_d[`COBX_XO_RSV1_LO +: 2] = xo_rsv1_q;
          rdata_d[`COBX_XO_LDO] = xo_ldo_q;
          rdata_d[`COBX_XO_GAIN_LO +: 2] = xo_gain_q;
          rdata_d[`COBX_XO_CAPOUT_LO +: 6] = xo_capout_q;
          rdata_d[`COBX_XO_RSV0_LO +: 2] = xo_rsv0_q;
          rdata_d[`COBX_XO_CAPIN_LO +: 6] = xo_capin_q;
        end
        `COBX_IDX_OD_CFG: begin
          rdata_d[`COBX_OD_LDO] = od_ldo_q;
          rdata_d[`COBX_OD_RATIO_LO +: 14] = od_ratio_q;
        end
        `COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL: begin
          rdata_d[`COBX_DRV_STATE_LO +: 2] = drv_state_q;
          rdata_d[`COBX_DRV_DIS] = drv_dis_q;
          rdata_d[`COBX_DRV_PD] = drv_pd_q;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Output divider and driver
  // ****************************************************************
  logic [13:0] div_cnt_q, div_cnt_d;
  logic div_clk_q, div_clk_d;
  logic true_q, true_d;
  logic comp_q, comp_d;
  logic true_oe_q, true_oe_d;
  logic comp_oe_q, comp_oe_d;
  logic [13:0] ratio;
  logic drv_off;

  assign ratio = (od_ratio_q < `COBX_OD_RATIO_MIN) ?
                 `COBX_OD_RATIO_MIN : od_ratio_q;
  assign drv_off = drv_dis_q || oe_sync_q[1];

  // Divided clock, high for the first half of each period
  always_comb begin
    div_cnt_d = (div_cnt_q >= ratio - 14'h0001) ? 14'h0000 :
                div_cnt_q + 14'h0001;
    div_clk_d = (div_cnt_d < {1'b0, ratio[13:1]});
    true_d = div_clk_q;
    comp_d = !div_clk_q;
    true_oe_d = 1'b1;
    comp_oe_d = 1'b1;
    if (drv_pd_q) begin
      true_d = 1'b0;
      comp_d = 1'b0;
      true_oe_d = 1'b0;
      comp_oe_d = 1'b0;
    end else if (drv_off) begin
      case (drv_state_q)
        `COBX_DIS_LOW_LOW: begin
          true_d = 1'b0;
          comp_d = lvds_mode;
        end
        `COBX_DIS_LOW_HIGH: begin
          true_d = 1'b0;
          comp_d = 1'b1;
        end
        `COBX_DIS_HIZ: begin
          true_d = 1'b0;
          comp_d = 1'b0;
          true_oe_d = 1'b0;
          comp_oe_d = 1'b0;
        end
        default: begin
          true_d = div_clk_q;
          comp_d = !div_clk_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 14'h0000;
      div_clk_q <= 1'b0;
      true_q <= 1'b0;
      comp_q <= 1'b0;
      true_oe_q <= 1'b0;
      comp_oe_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      div_clk_q <= div_clk_d;
      true_q <= true_d;
      comp_q <= comp_d;
      true_oe_q <= true_oe_d;
      comp_oe_q <= comp_oe_d;
    end
  end

  assign clock_out_true = true_q;
  assign clock_out_complement = comp_q;
  assign clock_out_true_oe = true_oe_q;
  assign clock_out_complement_oe = comp_oe_q;

endmodule : cobx_regs

// ==== tb/cobx_regs_props.sv ====
// Purpose: Port checker for the clock output and bias registers
// Assumes: Indices and fields come from cobx_cfg.svh
// Notes: Shadows the driver word to predict the pins
`timescale 1ns/10ps
`include "cobx_cfg.svh"

module cobx_props (
  input wire logic clk,
  input wire logic rst,
  input wire cobx_pkg::cobx_idx_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic lvds_mode,
  input wire cobx_pkg::cobx_code_t bias_code_applied,
  input wire logic osc_regulator_on,
  input wire logic [1:0] osc_gain_boost,
  input wire logic [5:0] osc_cap_in,
  input wire logic divider_regulator_on,
  input wire logic clock_out_true,
  input wire logic clock_out_true_oe,
  input wire logic clock_out_complement,
  input wire logic clock_out_complement_oe
);
  import cobx_pkg::*;
  logic [3:0] drv_d, drv_q;
  logic [7:0] age_d, age_q;
  logic [5:0] cap_lim;
  logic stat_rd, xo_wr, od_wr, pins_on;

  // Driver word shadow and saturating age since reset release
  always_comb begin
    drv_d = (reg_wr && reg_addr == `COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL) ? reg_wdata[3:0] : drv_q;
    age_d = (age_q == 8'hff) ? age_q : age_q + 8'h01;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_q <= 4'h0;
      age_q <= 8'h00;
    end else begin
      drv_q <= drv_d;
      age_q <= age_d;
    end
  end

  // Decoded strokes; capacitance above 0x2f is clamped at the pin
  assign stat_rd = reg_rd && reg_addr == `COBX_IDX_BIAS_STS;
  assign xo_wr = reg_wr && reg_addr == `COBX_IDX_XO_CFG;
  assign od_wr = reg_wr && reg_addr == `COBX_IDX_OD_CFG;
  assign cap_lim = (reg_wdata[5:0] > 6'h2f) ? 6'h2f : reg_wdata[5:0];
  assign pins_on = clock_out_true_oe && clock_out_complement_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Status read and the cycle its word appears
  sequence s_stat_rd;
    stat_rd ##1 1'b1;
  endsequence

  a_done_early: assert property (
    stat_rd && age_q < 8'h28 |=> !reg_rdata[0])
    else $error("done flag set while calibrating");
  a_done_late: assert property (
    stat_rd && age_q > 8'h5a |=> reg_rdata[0])
    else $error("done flag missing after calibration");
  a_eff_code: assert property (
    s_stat_rd |-> !reg_rdata[0] ||
    reg_rdata[7:5] == (reg_rdata[1] ? 3'h4 : reg_rdata[4:2]))
    else $error("effective code disagrees with selected code");
  a_eff_applied: assert property (
    s_stat_rd |-> !reg_rdata[0] || reg_rdata[7:5] == bias_code_applied)
    else $error("effective code differs from applied code");
  a_xo_fields: assert property (
    xo_wr |=> osc_regulator_on == $past(reg_wdata[16]) &&
    osc_gain_boost == $past(reg_wdata[15:14]))
    else $error("oscillator fields not taken");
  a_cap_clamp: assert property (
    xo_wr |=> osc_cap_in == $past(cap_lim))
    else $error("input capacitance wrong");
  a_div_ldo: assert property (
    od_wr |=> divider_regulator_on == $past(reg_wdata[15]))
    else $error("divider regulator wrong");
  a_pd_float: assert property (
    $past(drv_q[0]) |-> !pins_on && !clock_out_true_oe &&
    !clock_out_complement_oe && !clock_out_true)
    else $error("pins driven while powered down");
  a_hiz_state: assert property (
    $past(drv_q) == 4'b1010 |->
    !clock_out_true_oe && !clock_out_complement_oe)
    else $error("hi-z state driven");
  a_low_high: assert property (
    $past(drv_q) == 4'b0110 |->
    pins_on && !clock_out_true && clock_out_complement)
    else $error("low high state wrong");
  a_low_lvds: assert property (
    $past(drv_q) == 4'b0010 |-> pins_on && !clock_out_true &&
    clock_out_complement == $past(lvds_mode))
    else $error("low state wrong");
  a_debug_run: assert property (
    $past(drv_q) == 4'b1110 |->
    pins_on && clock_out_complement != clock_out_true)
    else $error("debug state not running");
endmodule : cobx_props

bind cobx_regs cobx_props u_props (.clk, .rst, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .lvds_mode, .bias_code_applied, .osc_regulator_on,
  .osc_gain_boost, .osc_cap_in, .divider_regulator_on, .clock_out_true,
  .clock_out_true_oe, .clock_out_complement, .clock_out_complement_oe);

// ==== tb/cobx_regs_tb.sv ====
// Purpose: Self-checking bench for the clock output and bias registers
// Assumes: Inputs change on the falling edge
// Notes: Comparator held static so calibration ends in a known code
`timescale 1ns/10ps
`include "cobx_cfg.svh"

module cobx_regs_tb;
  import cobx_pkg::*;
  logic clk, rst, reg_wr, reg_rd, cmp, oe_dis, lvds;
  logic t, t_oe, c, c_oe, ldo_xo, ldo_od;
  cobx_idx_t reg_addr;
  cobx_code_t code_app;
  logic [1:0] gain;
  logic [5:0] cap_o, cap_i;
  logic [31:0] reg_wdata, reg_rdata, rd_val, d;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int highs, r;

  cobx_regs u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .bias_cmp_pin(cmp), .oe_pin_disable(oe_dis),
    .lvds_mode(lvds), .bias_code_applied(code_app),
    .osc_regulator_on(ldo_xo), .osc_gain_boost(gain), .osc_cap_out(cap_o),
    .osc_cap_in(cap_i), .divider_regulator_on(ldo_od),
    .clock_out_true(t), .clock_out_true_oe(t_oe),
    .clock_out_complement(c), .clock_out_complement_oe(c_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far above the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Bus strokes, entered and left on a falling edge
  task automatic wr(input cobx_idx_t a, input logic [31:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input cobx_idx_t a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    rd_val = reg_rdata;
  endtask : rd

  // Clamp of a capacitance code to the top legal step
  function automatic logic [5:0] lim(input logic [5:0] v);
    return (v > `COBX_XO_CAP_MAX) ? `COBX_XO_CAP_MAX : v;
  endfunction : lim

  // Status after a static comparator: code rails, fails, falls back to 4
  function automatic logic [31:0] stat_w(input logic cv);
    return {23'h0, cv, 3'h4, {3{cv}}, 2'b11};
  endfunction : stat_w

  // Pin check after the enable sync and pin register settle
  task automatic pins(input logic pd, input logic dis, input logic [1:0] cd);
    idle(4);
    if (pd) chk({t, t_oe, c, c_oe}, 4'h0);
    else if (dis && cd == 2'h2) chk({t_oe, c_oe}, 2'h0);
    else if (dis && cd == 2'h0) chk({t, t_oe, c, c_oe}, {2'b01, lvds, 1'b1});
    else if (dis && cd == 2'h1) chk({t, t_oe, c, c_oe}, 4'h7);
    else chk({t_oe, c_oe, c ^ t}, 3'h7);
  endtask : pins

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 32'h0;
    cmp = 1'b1;
    oe_dis = 1'b0;
    lvds = 1'b0;
    void'($urandom(32'hd9fd1113));
    idle(5);
    rst = 1'b0;
    idle(2);
    rd(`COBX_IDX_BIAS_STS);
    chk(rd_val[0], 1'b0);
    // Regulator on, one boost amplifier, both caps at 0x1f
    d = {17'h0, 3'h5, 12'h7df};
    chk({ldo_xo, gain, cap_o, cap_i}, d);
    chk(ldo_od, 1'b1);
    rd(`COBX_IDX_XO_CFG);
    chk(rd_val, 32'h00015f1f);
    rd(`COBX_IDX_OD_CFG);
    chk(rd_val, 32'h00008069);
    rd(`COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL);
    chk(rd_val, 32'h0);
    idle(100);
    rd(`COBX_IDX_BIAS_STS);
    chk(rd_val, stat_w(1'b1));
    chk(code_app, 3'h4);
    $display("done: reset and calibration high");
    // Oscillator word with capacitance corners first
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      if (i < 3) begin
        d[13:8] = 6'h2f + 6'(i * 8);
        d[5:0] = 6'h2e + 6'(i);
      end
      wr(`COBX_IDX_XO_CFG, d);
      chk({ldo_xo, gain, cap_o, cap_i}, {d[16:14], lim(d[13:8]), lim(d[5:0])});
      rd(`COBX_IDX_XO_CFG);
      chk(rd_val, d & 32'h0007ffff);
    end
    $display("done: oscillator");
    // Every driver word, with lvds toggled across the sweep
    for (int i = 0; i < 32; i++) begin
      lvds = i[4];
      wr(`COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL, ($urandom() & 32'hfffffff0) | i[3:0]);
      pins(i[0], i[1], i[3:2]);
      rd(`COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL);
      chk(rd_val, {28'h0, i[3:0]});
    end
    oe_dis = 1'b1;
    wr(`COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL, 32'h4);
    pins(1'b0, 1'b1, 2'h1);
    wr(`COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL, 32'h1);
    pins(1'b1, 1'b1, 2'h1);
    oe_dis = 1'b0;
    wr(`COBX_IDX_OUTPUT_DRIVER_ENABLE_CONTROL, 32'h0);
    // Let the write strobe rest one cycle before the next stroke
    idle(1);
    $display("done: driver states");
    // Even ratios give exactly r high samples over two periods
    for (int k = 0; k < 3; k++) begin
      r = (k == 0) ? 10 : 10 + 2 * $urandom_range(15);
      d = ($urandom() & 32'hffffc000) | r;
      wr(`COBX_IDX_OD_CFG, d);
      chk(ldo_od, d[15]);
      rd(`COBX_IDX_OD_CFG);
      chk(rd_val, d & 32'h0000bfff);
      idle(120);
      highs = 0;
      repeat (2 * r) begin
        @(negedge clk);
        highs += t;
      end
      chk(highs, r);
    end
    $display("done: divider");
    // Second reset with the comparator low, then live comparator
    cmp = 1'b0;
    rst = 1'b1;
    idle(5);
    rst = 1'b0;
    idle(100);
    rd(`COBX_IDX_BIAS_STS);
    chk(rd_val, stat_w(1'b0));
    cmp = 1'b1;
    idle(4);
    rd(`COBX_IDX_BIAS_STS);
    chk(rd_val, stat_w(1'b0) | 32'h100);
    wr(`COBX_IDX_BIAS_STS, $urandom());
    rd(`COBX_IDX_BIAS_STS);
    chk(rd_val, stat_w(1'b0) | 32'h100);
    $display("done: calibration low and status");
    wrap_up();
  end
endmodule : cobx_regs_tb
